// ---- pess_pkg.sv ----
// Package of constants and types for the program end and soak sequencer.
package pess_pkg;
	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h01;
	localparam logic [7:0] ADR_BANK = 8'h02;
	localparam logic [7:0] ADR_ENDB = 8'h03;
	localparam logic [7:0] ADR_ASG0 = 8'h04;
	localparam logic [7:0] ADR_REM = 8'h08;
	localparam logic [7:0] ADR_SPR = 8'h09;
	localparam logic [7:0] ADR_BANKP = 8'h10;
	// ------------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------------
	localparam int CTRL_PAT = 0;
	localparam int CTRL_START = 2;
	localparam int CTRL_EVMODE = 3;
	localparam int CTRL_RSP = 4;
	localparam int STAT_END = 0;
	localparam int STAT_RUN = 1;
	localparam int STAT_AT = 2;
	localparam int STAT_PROG = 3;
	localparam logic [1:0] FLD_SP = 2'h0;
	localparam logic [1:0] FLD_SOAK = 2'h1;
	localparam logic [1:0] FLD_RAMP = 2'h2;
	localparam logic [1:0] FLD_WB = 2'h3;
	localparam logic [1:0] PAT_OFF = 2'h0;
	localparam logic [1:0] PAT_STOP = 2'h1;
	localparam logic [1:0] PAT_KEEP_RUNNING_PATTERN = 2'h2;
	localparam logic [1:0] PAT_LOOP = 2'h3;
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_FIRST_ALARM_FUNCTION = 2'h1;
	localparam logic [1:0] SRC_END = 2'h2;
	// ------------------------------------------------------------------
	// Range limit and timing
	// ------------------------------------------------------------------
	localparam logic [15:0] PV_RANGE_HI = 16'hffff;
	localparam int CLK_MHZ = 200;
	localparam int TICK_MS = 500;
	localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_ENDED} pess_st_e;
endpackage

// ---- pess_tmr_if.sv ----
// Interface between the sequencer and its soak timer.
`timescale 1ns/10ps
interface pess_tmr_if;
	logic tick;
	logic run;
	logic clear;
	logic [15:0] target;
	logic [16:0] remain;
	logic expired;
	modport seq (output tick, run, clear, target, input remain, expired);
	modport tmr (input tick, run, clear, target, output remain, expired);
endinterface

// ---- pess_soak_timer.sv ----
// Soak timer counting half-second ticks against a soak time in seconds.
`timescale 1ns/10ps
module pess_soak_timer import pess_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_nrst,
	pess_tmr_if.tmr t
);
	typedef struct packed {
		logic [16:0] elapsed;
	} pess_tmr_s;

	pess_tmr_s s_q;
	pess_tmr_s s_d;
	logic [16:0] goal;

	assign goal = {t.target, 1'b0};
	// A zero soak time counts as already elapsed, so such banks are skipped.
	assign t.expired = (s_q.elapsed >= goal);
	assign t.remain = t.expired ? 17'h00000 : 17'(goal - s_q.elapsed);

	always_comb begin
		s_d = s_q;
		if (t.clear) begin
			s_d.elapsed = 17'h00000;
		end else if (t.tick && t.run && !t.expired) begin
			// Only the elapsed count is kept, so a new soak time resumes.
			s_d.elapsed = 17'(s_q.elapsed + 17'h00001);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // pess_soak_timer

// ---- pess_sequencer.sv ----
// Program end and soak sequencer with its register port.
// Operation
// - At end hold end bank, end on; stop pattern stops, others keep running.
// - Executing bank may be changed during a run by event or key.
// - Any change of program pattern resets the bank to zero.
// - After end show process value; alternate setpoint and end every 0.5 s.
// - Pattern off to active routes the end output to auxiliary output one.
// - Pattern active to off gives auxiliary output one back to alarm one.
// - End signal routable to any output and visible in the status word.
// - Start going from started to reset clears end output and end display.
// - Event clears end; with start on event, start setting is monitor only.
// - Ramp carries into the next bank when that bank's rate is nonzero.
// - A zero ramp rate in the next bank stops ramping on entry.
// - Bank zero with zero rate and soak starts from its local setpoint.
// - Changing the soak time keeps the elapsed count.
// - Power restoration clears the soak timer, program stays started.
// - Sensor error keeps timing against the input range upper limit.
// - Timing continues through manual mode and run/stop toggles.
// - Auto-tuning may start; remaining shows zero, a step to a later bank waits for done.
// - Tuning at end: stop pattern stops it, others keep it running.
// - Start, reset, source change in any mode; time against chosen setpoint.
// - Remote setpoint error keeps timing on values held at the error.
// - A bank change by event, bank write or step clears elapsed time and restarts on the new bank.
// - Timer advances only inside the wait band; band off means unlimited.
// - On soak elapsed step to next bank, skipping zero soak banks.
`timescale 1ns/10ps
module pess_sequencer import pess_pkg::*; #(
	parameter int NB = 8,
	parameter int NO = 2,
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic [15:0] i_pv,
	input wire logic [15:0] i_rsp,
	input wire logic i_pv_err,
	input wire logic i_rsp_err,
	input wire logic i_ev_start,
	input wire logic i_ev_bank_wr,
	input wire logic [$clog2(NB)-1:0] i_ev_bank,
	input wire logic i_ev_end_clr,
	input wire logic i_run_key,
	input wire logic i_stop_key,
	input wire logic i_at_start,
	input wire logic i_at_done,
	input wire logic i_pwr_restore,
	input wire logic i_alarm1,
	output logic o_run,
	output logic o_end,
	output logic o_at_active,
	output logic o_at_stop,
	output logic [$clog2(NB)-1:0] o_bank,
	output logic [15:0] o_sp,
	output logic [NO-1:0] o_aux,
	output logic [15:0] o_disp1,
	output logic [15:0] o_disp2,
	output logic o_disp2_end
);
	localparam int BW = $clog2(NB);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		pess_st_e st;
		logic [1:0] pat;
		logic start_reg;
		logic ev_mode;
		logic rsp_mode;
		logic start_prev;
		logic [BW-1:0] bank;
		logic [BW-1:0] end_bank;
		logic [NO-1:0][1:0] asg;
		logic [NB-1:0][15:0] sp;
		logic [NB-1:0][15:0] soak;
		logic [NB-1:0][15:0] ramp;
		logic [NB-1:0][15:0] wb;
		logic [15:0] sp_r;
		logic [15:0] pv_hold;
		logic [15:0] rsp_hold;
		logic run;
		logic endf;
		logic at;
		logic at_stop;
		logic blink;
		logic [NO-1:0] aux;
		logic [15:0] d1;
		logic [15:0] d2;
		logic d2_end;
		logic [15:0] rdata;
		logic [31:0] tcnt;
		logic tick;
	} pess_s;

	pess_s s_q;
	pess_s s_d;
	pess_tmr_if tif ();

	logic program_started_eff;
	logic [15:0] pv_eff;
	logic [15:0] tgt;
	logic [16:0] dev;
	logic in_band;
	logic [7:0] boff;
	logic bsel;
	logic [BW-1:0] bidx;
	logic [BW-1:0] nxt_bank;
	logic nxt_found;
	logic [BW-1:0] first_bank;
	logic advance;
	logic clr;
	logic [15:0] rd_val;
	logic [15:0] local_setpoint;
	logic [16:0] gap;

	pess_soak_timer u_tmr (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.t(tif)
	);

	// ------------------------------------------------------------------
	// Timing reference and wait band
	// ------------------------------------------------------------------
	assign program_started_eff = s_q.ev_mode ? i_ev_start : s_q.start_reg;
	// A sensor error pins the value to the range top; a remote error holds.
	assign pv_eff = i_pv_err ? PV_RANGE_HI :
		(i_rsp_err ? s_q.pv_hold : i_pv);
	assign local_setpoint = s_q.sp[s_q.bank];
	assign tgt = s_q.rsp_mode ? (i_rsp_err ? s_q.rsp_hold : i_rsp) :
		local_setpoint;
	assign dev = (pv_eff >= tgt) ? 17'({1'b0, pv_eff} - {1'b0, tgt}) :
		17'({1'b0, tgt} - {1'b0, pv_eff});
	assign in_band = (s_q.wb[s_q.bank] == 16'h0000) ||
		(dev <= {1'b0, s_q.wb[s_q.bank]});

	assign boff = 8'(i_addr - ADR_BANKP);
	assign bsel = (i_addr >= ADR_BANKP) && (boff < 8'(NB * 4));
	assign bidx = boff[BW+1:2];

	// ------------------------------------------------------------------
	// Next bank search
	// ------------------------------------------------------------------
	always_comb begin
		nxt_bank = s_q.bank;
		nxt_found = 1'b0;
		first_bank = '0;
		for (int i = NB - 1; i >= 0; i--) begin
			if (i > int'(s_q.bank) && i <= int'(s_q.end_bank) &&
				s_q.soak[i] != 16'h0000) begin
				nxt_bank = BW'(i);
				nxt_found = 1'b1;
			end
			if (i <= int'(s_q.end_bank) && s_q.soak[i] != 16'h0000) begin
				first_bank = BW'(i);
			end
		end
	end

	// Tuning defers a step to a later bank; the end bank still ends, or loops back under the loop pattern.
	assign advance = (s_q.st == ST_RUN) && tif.expired &&
		(!s_q.at || !nxt_found);

	// ------------------------------------------------------------------
	// Soak timer control
	// ------------------------------------------------------------------
	assign clr = (program_started_eff && !s_q.start_prev) || advance ||
		i_ev_bank_wr || (i_wr && i_addr == ADR_BANK) || i_pwr_restore;
	assign tif.tick = s_q.tick;
	// Manual mode and the run flag do not gate the timer.
	assign tif.run = (s_q.st == ST_RUN) && in_band;
	assign tif.clear = clr;
	assign tif.target = s_q.soak[s_q.bank];

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always_comb begin
		rd_val = 16'h0000;
		if (i_addr == ADR_CTRL) begin
			rd_val[CTRL_PAT +: 2] = s_q.pat;
			rd_val[CTRL_START] = program_started_eff;
			rd_val[CTRL_EVMODE] = s_q.ev_mode;
			rd_val[CTRL_RSP] = s_q.rsp_mode;
		end else if (i_addr == ADR_STAT) begin
			rd_val[STAT_END] = s_q.endf;
			rd_val[STAT_RUN] = s_q.run;
			rd_val[STAT_AT] = s_q.at;
			rd_val[STAT_PROG] = (s_q.st == ST_RUN);
		end else if (i_addr == ADR_BANK) begin
			rd_val = 16'(s_q.bank);
		end else if (i_addr == ADR_ENDB) begin
			rd_val = 16'(s_q.end_bank);
		end else if (i_addr >= ADR_ASG0 && i_addr < 8'(ADR_ASG0 + NO)) begin
			rd_val = 16'(s_q.asg[2'(i_addr - ADR_ASG0)]);
		end else if (i_addr == ADR_REM) begin
			// The remaining soak time reads zero while tuning runs.
			rd_val = s_q.at ? 16'h0000 : tif.remain[16:1];
		end else if (i_addr == ADR_SPR) begin
			rd_val = s_q.sp_r;
		end else if (bsel) begin
			case (boff[1:0])
				FLD_SP: rd_val = s_q.sp[bidx];
				FLD_SOAK: rd_val = s_q.soak[bidx];
				FLD_RAMP: rd_val = s_q.ramp[bidx];
				default: rd_val = s_q.wb[bidx];
			endcase
		end
	end

	assign gap = (local_setpoint >= s_q.sp_r) ? 17'({1'b0, local_setpoint} - {1'b0, s_q.sp_r}) :
		17'({1'b0, s_q.sp_r} - {1'b0, local_setpoint});

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.at_stop = 1'b0;
		s_d.rdata = i_rd ? rd_val : 16'h0000;
		s_d.tick = 1'b0;
		s_d.tcnt = 32'(s_q.tcnt + 32'h00000001);
		if (s_q.tcnt >= 32'(TICK_CYCLES - 1)) begin
			s_d.tcnt = 32'h00000000;
			s_d.tick = 1'b1;
		end
		if (!i_rsp_err) begin
			s_d.pv_hold = i_pv;
			s_d.rsp_hold = i_rsp;
		end
		if (i_run_key) begin
			s_d.run = 1'b1;
		end else if (i_stop_key) begin
			s_d.run = 1'b0;
		end
		if (i_at_start) begin
			s_d.at = 1'b1;
		end else if (i_at_done) begin
			s_d.at = 1'b0;
		end

		// Register writes.
		if (i_wr) begin
			if (i_addr == ADR_CTRL) begin
				s_d.pat = i_wdata[CTRL_PAT +: 2];
				s_d.ev_mode = i_wdata[CTRL_EVMODE];
				s_d.rsp_mode = i_wdata[CTRL_RSP];
				if (!s_q.ev_mode) begin
					s_d.start_reg = i_wdata[CTRL_START];
				end
				if (i_wdata[CTRL_PAT +: 2] != s_q.pat) begin
					s_d.bank = '0;
					if (s_q.pat == PAT_OFF) begin
						s_d.asg[0] = SRC_END;
					end else if (i_wdata[CTRL_PAT +: 2] == PAT_OFF) begin
						s_d.asg[0] = SRC_FIRST_ALARM_FUNCTION;
					end
				end
			end else if (i_addr == ADR_BANK) begin
				s_d.bank = i_wdata[BW-1:0];
			end else if (i_addr == ADR_ENDB) begin
				s_d.end_bank = i_wdata[BW-1:0];
			end else if (i_addr >= ADR_ASG0 &&
				i_addr < 8'(ADR_ASG0 + NO)) begin
				s_d.asg[2'(i_addr - ADR_ASG0)] = i_wdata[1:0];
			end else if (bsel) begin
				case (boff[1:0])
					FLD_SP: s_d.sp[bidx] = i_wdata;
					FLD_SOAK: s_d.soak[bidx] = i_wdata;
					FLD_RAMP: s_d.ramp[bidx] = i_wdata;
					default: s_d.wb[bidx] = i_wdata;
				endcase
			end
		end
		if (i_ev_bank_wr) begin
			s_d.bank = i_ev_bank;
		end

		// An end reached in the cycle of a clear event still sets the flag.
		if (i_ev_end_clr) begin
			s_d.endf = 1'b0;
		end

		// Program sequencing.
		s_d.start_prev = program_started_eff;
		case (s_q.st)
			ST_IDLE: begin
				s_d.sp_r = local_setpoint;
			end
			ST_RUN: begin
				if (advance) begin
					if (nxt_found) begin
						s_d.bank = nxt_bank;
					end else if (s_q.pat == PAT_LOOP) begin
						s_d.bank = first_bank;
					end else begin
						s_d.st = ST_ENDED;
						s_d.endf = 1'b1;
						if (s_q.pat == PAT_STOP) begin
							s_d.run = 1'b0;
							s_d.at = 1'b0;
							s_d.at_stop = s_q.at;
						end
					end
				end
			end
			ST_ENDED: begin
				s_d.st = ST_ENDED;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Ramp follows the executing bank and carries across bank steps.
		if (s_q.st != ST_IDLE && s_q.tick) begin
			if (s_q.ramp[s_q.bank] == 16'h0000) begin
				s_d.sp_r = local_setpoint;
			end else if (gap <= {1'b0, s_q.ramp[s_q.bank]}) begin
				s_d.sp_r = local_setpoint;
			end else if (local_setpoint > s_q.sp_r) begin
				s_d.sp_r = 16'(s_q.sp_r + s_q.ramp[s_q.bank]);
			end else begin
				s_d.sp_r = 16'(s_q.sp_r - s_q.ramp[s_q.bank]);
			end
		end

		// Start and reset edges.
		if (s_q.pat != PAT_OFF && program_started_eff && !s_q.start_prev) begin
			s_d.st = ST_RUN;
			s_d.run = 1'b1;
			s_d.endf = 1'b0;
			if (s_q.ramp[0] == 16'h0000 && s_q.soak[0] == 16'h0000) begin
				s_d.sp_r = s_q.sp[0];
			end else begin
				s_d.sp_r = pv_eff;
			end
		end else if (!program_started_eff && s_q.start_prev) begin
			s_d.st = ST_IDLE;
			s_d.bank = '0;
			s_d.endf = 1'b0;
		end
		// Display and output routing.
		s_d.d1 = pv_eff;
		s_d.d2 = tgt;
		if (!s_d.endf) begin
			s_d.blink = 1'b0;
		end else if (s_q.tick) begin
			s_d.blink = !s_q.blink;
		end
		s_d.d2_end = s_d.endf && s_q.blink;
		for (int k = 0; k < NO; k++) begin
			s_d.aux[k] = (s_d.asg[k] == SRC_END) ? s_d.endf :
				((s_d.asg[k] == SRC_FIRST_ALARM_FUNCTION) ? i_alarm1 : 1'b0);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			s_q <= '0;
			s_q.asg[0] <= SRC_FIRST_ALARM_FUNCTION;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_rdata = s_q.rdata;
	assign o_run = s_q.run;
	assign o_end = s_q.endf;
	assign o_at_active = s_q.at;
	assign o_at_stop = s_q.at_stop;
	assign o_bank = s_q.bank;
	assign o_sp = s_q.sp_r;
	assign o_aux = s_q.aux;
	assign o_disp1 = s_q.d1;
	assign o_disp2 = s_q.d2;
	assign o_disp2_end = s_q.d2_end;
endmodule // pess_sequencer

// ---- pess_props.sv ----
// Port checker of the program end and soak sequencer.
`timescale 1ns/10ps
module pess_props import pess_pkg::*; #(
	parameter int NB = 8,
	parameter int TICK_CYCLES = 20
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_pv,
	input wire logic i_pv_err,
	input wire logic i_ev_bank_wr,
	input wire logic i_ev_end_clr,
	input wire logic [15:0] o_rdata,
	input wire logic o_run,
	input wire logic o_end,
	input wire logic o_at_active,
	input wire logic o_at_stop,
	input wire logic [$clog2(NB)-1:0] o_bank,
	input wire logic [15:0] o_disp1,
	input wire logic o_disp2_end
);
	// One blink phase lasts one tick; two ticks bound the wait.
	localparam int BLINK_MAX = 2 * TICK_CYCLES;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
		else $error("read data not zero outside an answer");
	a_end_held: assert property (
		o_end && $past(o_end) && !$past(i_wr) && !$past(i_ev_bank_wr)
		|-> $stable(o_bank)) else $error("bank moved while ended");
	a_end_clear: assert property (i_ev_end_clr && o_end |-> ##[1:2] !o_end)
		else $error("end not cleared by event");
	a_disp1_pv: assert property (
		(!i_pv_err && $stable(i_pv))[*3] |-> o_disp1 == i_pv)
		else $error("display one not process value");
	a_pv_err_top: assert property (
		i_pv_err[*3] |-> o_disp1 == PV_RANGE_HI)
		else $error("sensor error value not range top");
	a_blink_hold: assert property (
		o_end && $rose(o_disp2_end) |=> (o_disp2_end || !o_end)[*8])
		else $error("end indication too short");
	a_blink_rate: assert property (
		o_end && $rose(o_disp2_end)
		|-> ##[1:BLINK_MAX] (!o_disp2_end || !o_end))
		else $error("end indication does not alternate");
	a_at_hold: assert property (
		o_at_active && $past(o_at_active) && !$past(i_wr)
		&& !$past(i_ev_bank_wr) |-> $stable(o_bank))
		else $error("bank advanced during tuning");
	a_at_stop: assert property (
		o_at_stop |-> ##[0:2] (!o_at_active && !o_run && o_end))
		else $error("stop end did not stop tuning");
	c_end: cover property ($rose(o_end));
	c_at: cover property ($rose(o_at_active));
	c_blink: cover property (o_end && $rose(o_disp2_end));
	c_at_stop: cover property (o_at_stop);
endmodule // pess_props

// ---- pess_host_model.sv ----
// Host model driving the register port for keys and communications.
`timescale 1ns/10ps
module pess_host_model (
	input wire logic i_mclk,
	output logic [7:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	input wire logic [15:0] i_rdata
);
	initial begin
		o_addr = 8'h0;
		o_wdata = 16'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_mclk);
		v = i_rdata;
	endtask
endmodule // pess_host_model

// ---- test_pess_sequencer.sv ----
// Self-checking bench of the program end and soak sequencer.
`timescale 1ns/10ps
module test_pess_sequencer import pess_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, sp, d1, d2;
	logic [15:0] pv = 16'h10;
	logic wr, rd, run, fin, at_a, at_stop, d2e;
	logic pv_err = 1'b0;
	logic ev_bw = 1'b0;
	logic ev_clr = 1'b0;
	logic at_s = 1'b0;
	logic at_d = 1'b0;
	logic pwr = 1'b0;
	logic alm = 1'b0;
	logic ev_st = 1'b0;
	logic run_k = 1'b0;
	logic stop_k = 1'b0;
	logic [2:0] ev_bank = 3'h0;
	logic [2:0] bank;
	logic [1:0] aux;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	pess_sequencer #(.TICK_CYCLES(20)) i_dut (.i_mclk(clk), .i_nrst(nrst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_pv(pv), .i_rsp(16'h0), .i_pv_err(pv_err), .i_rsp_err(1'b0),
		.i_ev_start(ev_st), .i_ev_bank_wr(ev_bw), .i_ev_bank(ev_bank),
		.i_ev_end_clr(ev_clr), .i_run_key(run_k), .i_stop_key(stop_k),
		.i_at_start(at_s), .i_at_done(at_d), .i_pwr_restore(pwr),
		.i_alarm1(alm), .o_run(run), .o_end(fin), .o_at_active(at_a),
		.o_at_stop(at_stop), .o_bank(bank), .o_sp(sp), .o_aux(aux),
		.o_disp1(d1), .o_disp2(d2), .o_disp2_end(d2e));
	pess_host_model i_host (.i_mclk(clk), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd), .i_rdata(rdata));
	task print_verdict;
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		i_host.rd(a, v);
		chk(v, e);
	endtask
	task bp(input int b, input logic [1:0] f, input logic [15:0] v);
		i_host.wr(ADR_BANKP + 8'(4 * b) + 8'(f), v);
	endtask
	task cw(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wait_end;
		for (int n = 0; n < 1000 && fin !== 1'b1; n++)
			@(posedge clk);
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_reset;
		rc(ADR_STAT, 16'h0);
		rc(ADR_ASG0, 16'(SRC_FIRST_ALARM_FUNCTION));
		rc(8'h07, 16'h0);
		alm <= 1'b1;
		cw(3);
		chk(16'(aux[0]), 16'h1);
		alm <= 1'b0;
		$display("reset test done");
	endtask
	task t_pattern;
		i_host.wr(ADR_BANK, 16'h3);
		i_host.wr(ADR_CTRL, 16'(PAT_STOP));
		rc(ADR_BANK, 16'h0);
		rc(ADR_ASG0, 16'(SRC_END));
		i_host.wr(ADR_CTRL, 16'(PAT_OFF));
		rc(ADR_ASG0, 16'(SRC_FIRST_ALARM_FUNCTION));
		$display("pattern test done");
	endtask
	task t_end(input logic [1:0] p, input logic er, input logic ev);
		logic [15:0] v;
		logic d;
		i_host.wr(ADR_CTRL, 16'(p));
		i_host.wr(ADR_CTRL, 16'(p) | 16'h4);
		if (p == PAT_LOOP) begin
			for (int n = 0; n < 1000 && bank !== 3'h2; n++) @(posedge clk);
			for (int n = 0; n < 1000 && bank !== 3'h0; n++) @(posedge clk);
			chk(16'(bank), 16'h0);
			chk(16'(fin), 16'h0);
			chk(16'(run), 16'h1);
		end else begin
			wait_end();
			chk(16'(bank), 16'h2);
			chk(16'(run), 16'(er));
			i_host.rd(ADR_STAT, v);
			chk(16'(v[STAT_END]), 16'h1);
			chk(16'(aux[0]), 16'h1);
			chk(d1, pv);
			chk(d2, 16'h50);
			d = d2e;
			for (int n = 0; n < 30 && d2e === d; n++) @(posedge clk);
			chk(16'(d2e), 16'(!d));
			if (ev) begin
				@(posedge clk) ev_clr <= 1'b1;
				@(posedge clk) ev_clr <= 1'b0;
			end else
				i_host.wr(ADR_CTRL, 16'(p));
			cw(3);
			chk(16'(fin), 16'h0);
			chk(16'(d2e), 16'h0);
		end
		i_host.wr(ADR_CTRL, 16'h0);
		$display("end test pattern %0d done", p);
	endtask
	task t_evmode;
		i_host.wr(ADR_CTRL, 16'(PAT_KEEP_RUNNING_PATTERN) | 16'h8);
		ev_st <= 1'b1;
		wait_end();
		i_host.wr(ADR_CTRL, 16'(PAT_KEEP_RUNNING_PATTERN) | 16'h8);
		cw(2);
		chk(16'(fin), 16'h1);
		rc(ADR_CTRL, 16'he);
		ev_st <= 1'b0;
		cw(3);
		chk(16'(fin), 16'h0);
		chk(16'(bank), 16'h0);
		i_host.wr(ADR_CTRL, 16'h0);
		$display("event start test done");
	endtask
	task t_hold;
		logic [15:0] v;
		bp(0, FLD_SP, 16'h64);
		bp(0, FLD_SOAK, 16'h0);
		bp(1, FLD_SP, 16'h64);
		bp(1, FLD_SOAK, 16'h3);
		bp(2, FLD_SP, 16'h64);
		bp(2, FLD_SOAK, 16'h2);
		bp(2, FLD_WB, 16'h5);
		pv <= 16'h5a;
		i_host.wr(ADR_CTRL, 16'(PAT_STOP));
		i_host.wr(ADR_CTRL, 16'(PAT_STOP) | 16'h4);
		cw(3);
		chk(sp, 16'h64);
		chk(16'(bank), 16'h1);
		cw(50);
		pv <= 16'hc8;
		bp(1, FLD_WB, 16'h5);
		bp(1, FLD_SOAK, 16'h4);
		i_host.rd(ADR_REM, v);
		chk(16'(v < 16'h4), 16'h1);
		@(posedge clk) pwr <= 1'b1;
		@(posedge clk) pwr <= 1'b0;
		rc(ADR_REM, 16'h4);
		chk(16'(run), 16'h1);
		pv_err <= 1'b1;
		cw(4);
		chk(d1, 16'hffff);
		pv_err <= 1'b0;
		ev_bank <= 3'h2;
		@(posedge clk) ev_bw <= 1'b1;
		@(posedge clk) ev_bw <= 1'b0;
		cw(2);
		chk(16'(bank), 16'h2);
		rc(ADR_REM, 16'h2);
		ev_bank <= 3'h1;
		@(posedge clk) ev_bw <= 1'b1;
		@(posedge clk) ev_bw <= 1'b0;
		cw(2);
		chk(16'(bank), 16'h1);
		rc(ADR_REM, 16'h4);
		pv <= 16'h64;
		@(posedge clk) at_s <= 1'b1;
		@(posedge clk) at_s <= 1'b0;
		rc(ADR_REM, 16'h0);
		@(posedge clk) stop_k <= 1'b1;
		@(posedge clk) stop_k <= 1'b0;
		cw(100);
		chk(16'(run), 16'h0);
		@(posedge clk) run_k <= 1'b1;
		@(posedge clk) run_k <= 1'b0;
		cw(100);
		chk(16'(run), 16'h1);
		chk(16'(bank), 16'h1);
		chk(16'(fin), 16'h0);
		@(posedge clk) at_d <= 1'b1;
		@(posedge clk) at_d <= 1'b0;
		cw(2);
		chk(16'(bank), 16'h2);
		@(posedge clk) at_s <= 1'b1;
		@(posedge clk) at_s <= 1'b0;
		wait_end();
		chk(16'(fin), 16'h1);
		chk(16'(at_a), 16'h0);
		chk(16'(run), 16'h0);
		i_host.wr(ADR_CTRL, 16'(PAT_STOP));
		i_host.wr(ADR_CTRL, 16'h0);
		$display("soak hold test done");
	endtask
	initial begin
		cw(6);
		nrst <= 1'b1;
		cw(1);
		t_reset();
		t_pattern();
		bp(0, FLD_SOAK, 16'h1);
		bp(2, FLD_SOAK, 16'h1);
		bp(2, FLD_SP, 16'h50);
		i_host.wr(ADR_ENDB, 16'h2);
		t_end(PAT_STOP, 1'b0, 1'b0);
		t_end(PAT_KEEP_RUNNING_PATTERN, 1'b1, 1'b1);
		t_end(PAT_LOOP, 1'b1, 1'b0);
		t_evmode();
		t_hold();
		print_verdict();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			print_verdict();
		end
	end
endmodule // test_pess_sequencer
bind pess_sequencer pess_props #(.NB(NB), .TICK_CYCLES(TICK_CYCLES)) i_props (
	.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_pv(i_pv),
	.i_pv_err(i_pv_err), .i_ev_bank_wr(i_ev_bank_wr),
	.i_ev_end_clr(i_ev_end_clr), .o_rdata(o_rdata), .o_run(o_run),
	.o_end(o_end), .o_at_active(o_at_active), .o_at_stop(o_at_stop),
	.o_bank(o_bank), .o_disp1(o_disp1), .o_disp2_end(o_disp2_end));
